// >>> scsc_top.v
// APB register file, port 1 pins and channel output control of the serial channel standby block.
`timescale 1ns/1ps
`include "scsc_defs.vh"
module scsc_top (
    input  wire        i_ref_clk,
    input  wire        i_arst_n,
    input  wire        i_psel,
    input  wire        i_penable,
    input  wire        i_pwrite,
    input  wire [11:0] i_paddr,
    input  wire [31:0] i_pwdata,
    output reg  [31:0] o_prdata,
    output reg         o_pready,
    output reg         o_pslverr,
    input  wire [7:0]  i_port_pin,
    output reg  [7:0]  o_port_out,
    output reg  [7:0]  o_port_oe_n,
    input  wire        i_serial_in,
    output reg  [3:0]  o_ch_data_out,
    output reg  [3:0]  o_ch_clock_out,
    output reg         o_irq
);
    ////////////////////////////////////////////////////////////////////////////
    reg        rst_s1_q;
    reg        rst_n_q;
    reg [7:0]  pin_s1_q;
    reg [7:0]  pin_s2_q;
    reg        sin_s1_q;
    reg        sin_s2_q;

    always @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rst_s1_q <= 1'b0;
            rst_n_q  <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n_q  <= rst_s1_q;
        end
    end

    always @(posedge i_ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            pin_s1_q <= 8'h00;
            pin_s2_q <= 8'h00;
            sin_s1_q <= 1'b0;
            sin_s2_q <= 1'b0;
        end else begin
            pin_s1_q <= i_port_pin;
            pin_s2_q <= pin_s1_q;
            sin_s1_q <= i_serial_in;
            sin_s2_q <= sin_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    reg [7:0]  port_latch_q;
    reg [7:0]  port_dir_q;
    reg [7:0]  irq_flag_q;
    reg [7:0]  irq_mask_q;
    reg [15:0] so_level_q;
    reg [15:0] so_enable_q;
    reg [3:0]  op_enabled_q;
    reg [7:0]  tx_data_q;
    reg [7:0]  baud_q;
    reg        start_q;
    reg [31:0] rdata_d;
    reg        known_d;

    wire       access  = i_psel & i_penable & ~o_pready;
    wire       wr      = access & i_pwrite;
    wire       busy;
    wire       done;
    wire       sck;
    wire       sdo;
    wire [7:0] rx_data;

    function hit;
        input [11:0] addr;
        input [11:0] target;
        begin
            hit = (addr == target);
        end
    endfunction

    // Port read mixes pin level for input bits and the latch for output bits.
    wire [7:0] port_read = (port_dir_q & pin_s2_q) | (~port_dir_q & port_latch_q);

    always @* begin
        rdata_d = 32'h0000_0000;
        known_d = 1'b1;
        case (i_paddr)
            `SCSC_ADDR_PORT_LATCH: rdata_d[7:0] = port_read;
            `SCSC_ADDR_PORT_DIR:  rdata_d[7:0]  = port_dir_q;
            `SCSC_ADDR_IRQ_FLAG:  rdata_d[7:0]  = irq_flag_q;
            `SCSC_ADDR_IRQ_MASK:  rdata_d[7:0]  = irq_mask_q;
            `SCSC_ADDR_SO_LEVEL:  rdata_d[15:0] = so_level_q;
            `SCSC_ADDR_SO_ENABLE: rdata_d[15:0] = so_enable_q;
            `SCSC_ADDR_START:     rdata_d       = 32'h0000_0000;
            `SCSC_ADDR_STATUS:    rdata_d[4:0]  = {busy, op_enabled_q};
            `SCSC_ADDR_TX_DATA:   rdata_d[7:0]  = tx_data_q;
            `SCSC_ADDR_RX_DATA:   rdata_d[7:0]  = rx_data;
            `SCSC_ADDR_BAUD:      rdata_d[7:0]  = baud_q;
            default:              known_d       = 1'b0;
        endcase
    end

    always @(posedge i_ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            o_pready  <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata  <= 32'h0000_0000;
        end else begin
            o_pready  <= access;
            o_pslverr <= access & ~known_d;
            if (access && !i_pwrite) begin
                o_prdata <= rdata_d;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Writes land on the same edge that raises pready; the master holds the request until then.
    always @(posedge i_ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            port_latch_q <= `SCSC_RST_PORT_LATCH;
            port_dir_q   <= `SCSC_RST_PORT_DIR;
            irq_flag_q   <= `SCSC_RST_IRQ_FLAG;
            irq_mask_q   <= `SCSC_RST_IRQ_MASK;
            so_level_q   <= `SCSC_RST_SO_LEVEL;
            so_enable_q  <= `SCSC_RST_SO_ENABLE;
            op_enabled_q <= 4'h0;
            tx_data_q    <= 8'h00;
            baud_q       <= `SCSC_RST_BAUD;
            start_q      <= 1'b0;
        end else begin
            start_q <= 1'b0;
            if (wr && hit(i_paddr, `SCSC_ADDR_PORT_LATCH)) begin
                port_latch_q <= i_pwdata[7:0];
            end
            if (wr && hit(i_paddr, `SCSC_ADDR_PORT_DIR)) begin
                port_dir_q <= i_pwdata[7:0];
            end
            if (wr && hit(i_paddr, `SCSC_ADDR_IRQ_MASK)) begin
                irq_mask_q <= i_pwdata[7:0];
            end
            if (wr && hit(i_paddr, `SCSC_ADDR_SO_LEVEL)) begin
                so_level_q <= i_pwdata[15:0] & 16'h0F0F;
            end
            if (wr && hit(i_paddr, `SCSC_ADDR_SO_ENABLE)) begin
                so_enable_q <= i_pwdata[15:0] & 16'h000F;
            end
            if (wr && hit(i_paddr, `SCSC_ADDR_TX_DATA)) begin
                tx_data_q <= i_pwdata[7:0];
                start_q   <= op_enabled_q[0];
            end
            if (wr && hit(i_paddr, `SCSC_ADDR_BAUD)) begin
                baud_q <= i_pwdata[7:0];
            end
            // Start bits only set; a 0 written leaves the channel untouched.
            if (wr && hit(i_paddr, `SCSC_ADDR_START)) begin
                op_enabled_q <= op_enabled_q | i_pwdata[3:0];
            end
            // A completion in the same cycle as a software write keeps the flag set.
            if (wr && hit(i_paddr, `SCSC_ADDR_IRQ_FLAG)) begin
                irq_flag_q <= i_pwdata[7:0];
            end
            if (done) begin
                irq_flag_q[`SCSC_FLAG_CH0_BIT] <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // A transfer is started by writing transmit data once channel 0 is in its wait state.
    scsc_shifter #(
        .BITS       (8)
    ) u_shift (
        .i_clk      (i_ref_clk),
        .i_rst_n    (rst_n_q),
        .i_start    (start_q),
        .i_div      (baud_q),
        .i_tx       (tx_data_q),
        .i_sin      (sin_s2_q),
        .i_idle_sck (so_level_q[`SCSC_SO_CLK_BASE]),
        .i_idle_so  (so_level_q[0]),
        .o_busy     (busy),
        .o_done     (done),
        .o_sck      (sck),
        .o_so       (sdo),
        .o_rx       (rx_data)
    );

    ////////////////////////////////////////////////////////////////////////////
    integer k;
    always @(posedge i_ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            o_port_out     <= 8'h00;
            o_port_oe_n    <= 8'hFF;
            o_ch_data_out  <= 4'hF;
            o_ch_clock_out <= 4'hF;
            o_irq          <= 1'b0;
        end else begin
            o_port_oe_n <= port_dir_q;
            for (k = 0; k < 4; k = k + 1) begin
                o_ch_data_out[k]  <= so_level_q[k];
                o_ch_clock_out[k] <= so_level_q[`SCSC_SO_CLK_BASE + k];
            end
            if (so_enable_q[0]) begin
                o_ch_data_out[0]  <= sdo;
                o_ch_clock_out[0] <= sck;
            end
            // Output enable off leaves port bits 1:0 at the written latch levels and the channel pins at their written idle levels.
            o_port_out <= port_latch_q;
            if (so_enable_q[0]) begin
                o_port_out[1] <= sdo;
                o_port_out[0] <= sck;
            end
            o_irq <= irq_flag_q[`SCSC_FLAG_CH0_BIT] & ~irq_mask_q[`SCSC_FLAG_CH0_BIT];
        end
    end
endmodule // scsc_top

// >>> scsc_defs.vh
// Constants, register map and field layout of the serial channel standby control block.
// Function
// - The port 1 bit 0 latch drives its written level in output mode, and a read returns the pin level in input mode.
//   Here the serial clock drives bit 0 instead while the channel 0 output enable bit is 1.
// - A port 1 direction bit at 0 turns the output buffer on, and at 1 turns it off for input.
// - The channel 0 transfer-end flag reads 1 while a request is pending and 0 when none was generated.
// - The channel 0 mask bit at 0 enables the interrupt, and at 1 disables it.
// - The serial output register holds data levels from bit 0 and clock levels from bit 8, and the pins drive them.
// - A channel output enable bit at 1 lets the serial operation drive that channel's pins; only channel 0 has one here, so bits 1 to 3 drive nothing.
// - A channel output enable bit at 0 stops the serial operation from driving that channel's pins.
// - Writing 1 to a start bit sets the channel's operation-enabled bit and enters the wait state; 0 does nothing.
`ifndef SCSC_DEFS_VH
`define SCSC_DEFS_VH
`define SCSC_ADDR_PORT_LATCH 12'h000
`define SCSC_ADDR_PORT_DIR   12'h004
`define SCSC_ADDR_IRQ_FLAG   12'h008
`define SCSC_ADDR_IRQ_MASK   12'h00C
`define SCSC_ADDR_SO_LEVEL   12'h010
`define SCSC_ADDR_SO_ENABLE  12'h014
`define SCSC_ADDR_START      12'h018
`define SCSC_ADDR_STATUS     12'h01C
`define SCSC_ADDR_TX_DATA    12'h020
`define SCSC_ADDR_RX_DATA    12'h024
`define SCSC_ADDR_BAUD       12'h028
`define SCSC_FLAG_CH0_BIT    5
`define SCSC_SO_CLK_BASE     8
`define SCSC_RST_PORT_LATCH  8'h00
`define SCSC_RST_PORT_DIR    8'hFF
`define SCSC_RST_IRQ_FLAG    8'h00
`define SCSC_RST_IRQ_MASK    8'hFF
`define SCSC_RST_SO_LEVEL    16'h0F0F
`define SCSC_RST_SO_ENABLE   16'h0000
`define SCSC_RST_BAUD        8'h04
`endif

// >>> scsc_shifter.v
// Channel 0 eight-bit clocked serial shifter, MSB first, data changes on falling clock, sampled on rising.
`timescale 1ns/1ps
module scsc_shifter #(
    parameter BITS = 8
) (
    input  wire            i_clk,
    input  wire            i_rst_n,
    input  wire            i_start,
    input  wire [7:0]      i_div,
    input  wire [BITS-1:0] i_tx,
    input  wire            i_sin,
    input  wire            i_idle_sck,
    input  wire            i_idle_so,
    output reg             o_busy,
    output reg             o_done,
    output reg             o_sck,
    output reg             o_so,
    output reg  [BITS-1:0] o_rx
);
    reg [7:0]      div_cnt_q;
    reg [3:0]      edge_cnt_q;
    reg [BITS-1:0] sh_q;
    wire           tick = (div_cnt_q == 8'h00);

    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_busy     <= 1'b0;
            o_done     <= 1'b0;
            o_sck      <= 1'b1;
            o_so       <= 1'b1;
            o_rx       <= {BITS{1'b0}};
            div_cnt_q  <= 8'h00;
            edge_cnt_q <= 4'h0;
            sh_q       <= {BITS{1'b0}};
        end else begin
            o_done <= 1'b0;
            if (!o_busy) begin
                o_sck <= i_idle_sck;
                o_so  <= i_idle_so;
                if (i_start) begin
                    o_busy     <= 1'b1;
                    sh_q       <= i_tx;
                    div_cnt_q  <= i_div;
                    edge_cnt_q <= 4'h0;
                end
            end else if (tick) begin
                div_cnt_q <= i_div;
                if (edge_cnt_q[0] == 1'b0) begin
                    o_sck <= 1'b0;
                    o_so  <= sh_q[BITS-1];
                end else begin
                    o_sck <= 1'b1;
                    sh_q  <= {sh_q[BITS-2:0], i_sin};
                end
                if (edge_cnt_q == 4'hF) begin
                    o_busy <= 1'b0;
                    o_done <= 1'b1;
                    o_rx   <= {sh_q[BITS-2:0], i_sin};
                end
                edge_cnt_q <= edge_cnt_q + 4'h1;
            end else begin
                div_cnt_q <= div_cnt_q - 8'h01;
            end
        end
    end
endmodule // scsc_shifter

// >>> scsc_props.sv
// Port-level assertions and covers for the serial channel standby control block.
`timescale 1ns/1ps
`include "scsc_defs.vh"
module scsc_props (
    input logic        i_ref_clk,
    input logic        i_arst_n,
    input logic        i_psel,
    input logic        i_penable,
    input logic        i_pwrite,
    input logic [11:0] i_paddr,
    input logic [31:0] i_pwdata,
    input logic [31:0] o_prdata,
    input logic        o_pready,
    input logic        o_pslverr,
    input logic [7:0]  o_port_out,
    input logic [7:0]  o_port_oe_n,
    input logic [3:0]  o_ch_data_out,
    input logic [3:0]  o_ch_clock_out,
    input logic        o_irq
);
    // A write is taken on the edge that sees the access phase before the answer.
    wire wr = i_psel & i_penable & i_pwrite & ~o_pready;
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_arst_n);
    ready_pulse_a: assert property (o_pready |=> !o_pready)
        else $error("pready stood longer than one cycle");
    answer_wait_a: assert property (i_psel && i_penable && !o_pready |=> o_pready)
        else $error("access phase not answered after one wait cycle");
    slverr_ready_a: assert property (o_pslverr |-> o_pready)
        else $error("pslverr without pready");
    refused_read_a: assert property (o_pready && o_pslverr && !i_pwrite |-> o_prdata == 32'h0)
        else $error("refused read returned data");
    start_reads_zero_a: assert property (o_pready && !i_pwrite && i_paddr == `SCSC_ADDR_START |-> o_prdata == 32'h0)
        else $error("start trigger register read back nonzero");
    dir_to_oe_a: assert property (wr && i_paddr == `SCSC_ADDR_PORT_DIR |-> ##2 o_port_oe_n == $past(i_pwdata[7:0], 2))
        else $error("output enables do not follow direction write");
    latch_to_pin_a: assert property (wr && i_paddr == `SCSC_ADDR_PORT_LATCH |-> ##2 o_port_out[7:2] == $past(i_pwdata[7:2], 2))
        else $error("port outputs do not follow latch write");
    level_to_pins_a: assert property (wr && i_paddr == `SCSC_ADDR_SO_LEVEL |-> ##2
        {o_ch_clock_out[3:1], o_ch_data_out[3:1]} == {$past(i_pwdata[11:9], 2), $past(i_pwdata[3:1], 2)})
        else $error("channel levels do not follow level write");
    mask_blocks_irq_a: assert property (wr && i_paddr == `SCSC_ADDR_IRQ_MASK && i_pwdata[5] |-> ##2 !o_irq)
        else $error("interrupt raised while masked");
    irq_seen_c: cover property (o_irq);
    refused_c: cover property (o_pready && o_pslverr);
    start_c: cover property (wr && i_paddr == `SCSC_ADDR_START && i_pwdata[0]);
endmodule // scsc_props
bind scsc_top scsc_props u_props (.*);

// >>> scsc_eeprom.sv
// Behavioural serial EEPROM partner: takes bits on the rising clock, answers on the falling clock.
`timescale 1ns/1ps
module scsc_eeprom (
    input  logic       i_sck,
    input  logic       i_cs,
    input  logic       i_mosi,
    input  logic [7:0] i_reply,
    output logic       o_miso,
    output logic [7:0] o_got
);
    int cnt = 0;
    initial o_miso = 1'h0;
    // The answer bit changes on the falling clock so it is settled at the rising sample.
    always @(negedge i_sck) if (i_cs) o_miso <= i_reply[7 - cnt];
    // Edges while deselected, such as the pins settling out of reset, leave the bit count alone.
    always @(posedge i_sck) begin
        if (i_cs) begin
            o_got <= {o_got[6:0], i_mosi};
            cnt <= (cnt == 7) ? 0 : cnt + 1;
            // After the last bit the line holds no data, so it shows the inverse of the last value.
            if (cnt == 7) o_miso <= ~i_reply[0];
        end
    end
endmodule // scsc_eeprom

// >>> serial_channel_standby_control_bench.sv
// Self-checking bench for the serial channel standby control block.
`timescale 1ns/1ps
`include "scsc_defs.vh"
module serial_channel_standby_control_bench;
    logic        clk = 1'h0, rst_n = 1'h0, psel = 1'h0, pen = 1'h0, pwr = 1'h0, cs = 1'h0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, d;
    logic        pready, pslverr, irq, miso;
    logic [7:0]  ext = 8'h0, reply = 8'h0, port_out, port_oe_n, got, r, tx;
    logic [3:0]  ch_d, ch_c;
    logic [32:0] expq[$];
    logic [44:0] rst_tab[10] = '{{12'h000, 33'h0}, {12'h004, 33'hFF}, {12'h008, 33'h0}, {12'h00C, 33'hFF},
        {12'h010, 33'h0F0F}, {12'h014, 33'h0}, {12'h018, 33'h0}, {12'h01C, 33'h0}, {12'h028, 33'h4},
        {12'h030, 33'h100000000}};
    int          num_errors = 0, samples_checked = 0, n;
    // Each shared pin shows the block's level while it drives and the outside level otherwise.
    wire [7:0] pinw = (port_oe_n & ext) | (~port_oe_n & port_out);
    always #10 clk = ~clk;
    scsc_top i_dut (.i_ref_clk(clk), .i_arst_n(rst_n), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
        .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_port_pin(pinw), .o_port_out(port_out), .o_port_oe_n(port_oe_n), .i_serial_in(miso),
        .o_ch_data_out(ch_d), .o_ch_clock_out(ch_c), .o_irq(irq));
    scsc_eeprom i_mem (.i_sck(pinw[0]), .i_cs(cs), .i_mosi(pinw[1]), .i_reply(reply), .o_miso(miso),
        .o_got(got));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v);
        int k;
        k = 0;
        @(posedge clk);
        psel <= 1'h1;
        pwr <= w;
        paddr <= a;
        pwdata <= v;
        @(posedge clk);
        pen <= 1'h1;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'h1 && k < 50);
        psel <= 1'h0;
        pen <= 1'h0;
        if (k >= 50) chk(33'h0, 33'h1);
    endtask
    task automatic rd(input logic [11:0] a, input logic [32:0] e);
        expq.push_back(e);
        apb(1'h0, a, 32'h0);
    endtask
    task automatic end_sim;
        $display("checks %0d, mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Read answers are compared in arrival order against the notes left by the driver.
    always @(posedge clk) begin
        if (psel && pen && pready === 1'h1 && !pwr && expq.size() > 0) chk({pslverr, prdata}, expq.pop_front());
    end
    initial begin
        #100000;
        num_errors++;
        end_sim;
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'h2129));
        repeat (2) @(posedge clk);
        rst_n <= 1'h1;
        repeat (3) @(posedge clk);
        foreach (rst_tab[i]) rd(rst_tab[i][44:33], rst_tab[i][32:0]);
        $display("test reset values done");
        // Latch bits 1:0 stay high so they match the idle serial clock and data levels.
        r = 8'($urandom) | 8'h03;
        apb(1'h1, `SCSC_ADDR_PORT_LATCH, {24'h0, r});
        apb(1'h1, `SCSC_ADDR_PORT_DIR, 32'h0);
        @(posedge clk);
        #1 chk({25'h0, port_out}, {25'h0, r});
        chk({25'h0, port_oe_n}, 33'h0);
        ext <= 8'($urandom);
        apb(1'h1, `SCSC_ADDR_PORT_DIR, 32'hFC);
        rd(`SCSC_ADDR_PORT_LATCH, {25'h0, ext[7:2], r[1:0]});
        $display("test port pins done");
        d = $urandom & 32'h0F0F;
        apb(1'h1, `SCSC_ADDR_SO_LEVEL, d);
        @(posedge clk);
        #1 chk({25'h0, ch_c, ch_d}, {25'h0, d[11:8], d[3:0]});
        $display("test output levels done");
        apb(1'h1, `SCSC_ADDR_SO_LEVEL, 32'h0F0F);
        apb(1'h1, `SCSC_ADDR_IRQ_FLAG, 32'h0);
        apb(1'h1, `SCSC_ADDR_IRQ_MASK, 32'hDF);
        apb(1'h1, `SCSC_ADDR_BAUD, 32'h3);
        apb(1'h1, `SCSC_ADDR_SO_ENABLE, 32'h1);
        apb(1'h1, `SCSC_ADDR_START, 32'h0);
        rd(`SCSC_ADDR_STATUS, 33'h0);
        apb(1'h1, `SCSC_ADDR_START, 32'h1);
        rd(`SCSC_ADDR_STATUS, 33'h1);
        tx = 8'($urandom);
        reply <= 8'($urandom);
        // The partner is selected only now, so the pin edges of the port test never reach its bit count.
        cs <= 1'h1;
        apb(1'h1, `SCSC_ADDR_TX_DATA, {24'h0, tx});
        n = 0;
        while (irq !== 1'h1 && n < 400) begin
            @(posedge clk);
            n++;
        end
        chk({32'h0, irq}, 33'h1);
        rd(`SCSC_ADDR_IRQ_FLAG, 33'h20);
        rd(`SCSC_ADDR_RX_DATA, {25'h0, reply});
        chk({25'h0, got}, {25'h0, tx});
        apb(1'h1, `SCSC_ADDR_IRQ_MASK, 32'hFF);
        @(posedge clk);
        #1 chk({32'h0, irq}, 33'h0);
        apb(1'h1, `SCSC_ADDR_IRQ_FLAG, 32'h0);
        rd(`SCSC_ADDR_IRQ_FLAG, 33'h0);
        $display("test transfer done");
        end_sim;
    end
endmodule // serial_channel_standby_control_bench
